/* core/sec_params.svh */
// constants for the secure serial memory front end: timing, sizes, opcodes
// assumes a 25 MHz system clock; included by every design file that needs it
`ifndef SEC_PARAMS_SVH
`define SEC_PARAMS_SVH

`define CLK_HZ        25000000
`define REF_CLK_HZ    4915200
`define BAUD_RATE     9600
`define BAUD_DIV      (`CLK_HZ / `BAUD_RATE)
`define PROG_TIME_MS  12
`define PROG_CYCLES   (`PROG_TIME_MS * (`CLK_HZ / 1000))

`define MEM_BYTES     512
`define ADDR_W        9
`define ADDR_LAST     9'h1FF
`define CODE_MAX      8
`define FIFO_DEPTH    32
`define PTR_RESET     9'h000
`define CODE_LEN_RST  4'h0

`define OPB_READ      7'h01
`define OPB_SEQ       7'h02
`define OPB_WRITE     7'h03
`define OPB_SET_PROTECT_BOUND      7'h04
`define OP_EWEN       8'h20
`define OP_EWDS       8'h21
`define OP_BUSY_SIGNAL_ON_CMD      8'h22
`define OP_DISBSY     8'h23
`define OP_UNLOCK_WITH_CODE       8'h24
`define OP_DISAC      8'h25
`define OP_ONE_SHOT_BOUND_BYPASS      8'h26
`define OP_RSR        8'h27
`define OP_NOP        8'h28
`define OPN_CHANGE_PASSCODE      4'h3

`define STATUS_FIXED  3'h5
`define STATUS_RSVD   2'h0

`endif

/* core/sec_pkg.sv */
// types shared by the secure serial memory front end
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package sec_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_DATA  = 3'h2,
    ST_CODE  = 3'h3,
    ST_PUSH  = 3'h4,
    ST_SEQ   = 3'h5,
    ST_ERROR = 3'h6
  } cmd_state_type;
  typedef logic [7:0] status_word_type;
  typedef logic [8:0] addr_type;
endpackage
`default_nettype wire

/* core/byte_stream_if.sv */
// valid/ready byte carrier between the front end and its output fifo
// assumes both ends share one clock
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 8) ();
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

/* core/byte_fifo.sv */
// synchronous fifo with valid/ready on both sides and a flush input
// assumes DEPTH is a power of two
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic    clk_in,
  input  wire logic    rst_b_in,
  input  wire logic    clear_in,
  byte_stream_if.sink   wr_in,
  byte_stream_if.source rd_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push_w;
  wire              pop_w;

  assign push_w       = wr_in.valid && wr_in.ready;
  assign pop_w        = rd_out.valid && rd_out.ready;
  assign wr_in.ready  = !clear_in && (count_reg != (AW+1)'(DEPTH));
  assign rd_out.valid = !clear_in && (count_reg != '0);
  assign rd_out.data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk_in) begin
    if (push_w) begin
      mem_reg[wr_ptr_reg] <= wr_in.data;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (clear_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push_w) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop_w) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push_w && !pop_w) count_reg <= count_reg + 1'b1;
      else if (pop_w && !push_w) count_reg <= count_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* core/serial_rx.sv */
// start-bit serial receiver, lsb first, optional even parity, one stop bit
// assumes the line input is synchronous to clk_in and idles high
`default_nettype none
`include "sec_params.svh"
module serial_rx #(
  parameter int DIV = `BAUD_DIV
) (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       clear_in,
  input  wire logic       line_in,
  input  wire logic       parity_en_in,
  output logic            byte_valid_out,
  output logic [7:0]      byte_out,
  output logic            parity_err_out
);
  localparam int CW = $clog2(DIV + 1);

  logic          busy_reg;
  logic [3:0]    idx_reg;
  logic [CW-1:0] cnt_reg;
  logic [8:0]    shift_reg;
  wire           tick_w;
  wire [3:0]     stop_idx_w;
  wire           par_bad_w;

  assign tick_w     = busy_reg && (cnt_reg == '0);
  assign stop_idx_w = parity_en_in ? 4'hA : 4'h9;
  assign par_bad_w  = parity_en_in && (^shift_reg);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_reg       <= 1'b0;
      idx_reg        <= 4'h0;
      cnt_reg        <= '0;
      shift_reg      <= 9'h000;
      byte_valid_out <= 1'b0;
      byte_out       <= 8'h00;
      parity_err_out <= 1'b0;
    end else begin
      byte_valid_out <= 1'b0;
      parity_err_out <= 1'b0;
      if (clear_in) begin
        busy_reg <= 1'b0;
      end else if (!busy_reg) begin
        if (!line_in) begin
          busy_reg <= 1'b1;
          idx_reg  <= 4'h0;
          cnt_reg  <= CW'(DIV / 2);
        end
      end else if (!tick_w) begin
        cnt_reg <= cnt_reg - 1'b1;
      end else begin
        cnt_reg <= CW'(DIV - 1);
        idx_reg <= idx_reg + 4'h1;
        if (idx_reg == 4'h0 && line_in) begin
          busy_reg <= 1'b0;
        end else if (idx_reg == stop_idx_w) begin
          busy_reg       <= 1'b0;
          byte_valid_out <= 1'b1;
          byte_out       <= parity_en_in ? shift_reg[7:0] : shift_reg[8:1];
          parity_err_out <= par_bad_w;
        end else if (idx_reg != 4'h0) begin
          shift_reg <= {line_in, shift_reg[8:1]};
        end
      end
    end
  end

  AST_RX_PARITY_ONLY_WHEN_ON: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    parity_err_out |-> $past(parity_en_in) && byte_valid_out)
    else $error("parity error flagged with parity off");
endmodule
`default_nettype wire

/* core/secure_serial_eeprom_front_end.sv */
// command front end of a password protected 512 byte serial memory
// assumes inputs synchronous to clk_in; the pad logic resolves the enables
// How it works
// - bit timing comes from an internal clock divider, 9600 baud from the 25 MHz system clock.
// - idle ones after a command are ignored; a zero starts the next byte.
// - an instruction error aborts and silences serial input and output until chip select low.
// - chip select low resets the interface and floats the data output.
// - chip select reset keeps enables and lets a running program cycle finish.
// - program and access enables stay set until their disable command; access enable also clears on a failed unlock or a zero-length passcode change.
// - data output floats except while sending read or status words or showing busy.
// - with busy indication, output low while programming, then high until next opcode.
// - without busy indication, output floats during the program cycle.
// - any detected error floats the data output.
// - status read returns an 8-bit word; in error nothing is returned.
// - parity select high means even parity, low means none.
// - instruction or parity error pulls the error pin low until chip select low.
// - stream read sends consecutive bytes from a start address to memory end.
// - device holds a 1 to 8 byte passcode, its length and a bound address.
// - after reset passcode length is zero and bound is zero.
// - secured memory splits into writable and read-only parts without code or once unlocked, else into read-only and hidden parts.
// - without passcode, area below bound is read-only unless bypassed or moved.
// - program at locations below the bound is blocked unless bypassed.
// - status word is 101, parity error, instruction error, ready, two reserved.
`default_nettype none
`include "sec_params.svh"
module secure_serial_eeprom_front_end #(
  parameter int PROG_CYCLES = `PROG_CYCLES,
  parameter int BAUD_DIV    = `BAUD_DIV,
  parameter int FIFO_DEPTH  = `FIFO_DEPTH
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              cs_in,
  input  wire logic              serial_data_in,
  input  wire logic              parity_select_pin_in,
  output logic                   serial_data_out,
  output logic                   serial_data_oe_out,
  output logic                   err_out,
  output logic                   err_oe_out,
  output sec_pkg::status_word_type status_out
);
  import sec_pkg::*;

  localparam int PW = $clog2(PROG_CYCLES + 1);
  localparam int CW = $clog2(BAUD_DIV + 1);

  cmd_state_type   state_reg;
  logic [7:0]      op_reg;
  addr_type        addr_reg;
  addr_type        pointer_reg;
  logic [3:0]      cnt_reg;
  logic [3:0]      code_len_reg;
  logic [3:0]      new_len_reg;
  logic [7:0]      code_reg [`CODE_MAX];
  logic            match_reg;
  logic            prog_en_reg;
  logic            access_en_reg;
  logic            bypass_reg;
  logic            busy_en_reg;
  logic            hold_high_reg;
  logic            instr_err_reg;
  logic            par_err_reg;
  logic            push_status_reg;
  logic [PW-1:0]   prog_cnt_reg;
  logic [7:0]      mem_reg [`MEM_BYTES];
  logic            tx_active_reg;
  logic [10:0]     tx_shift_reg;
  logic [3:0]      tx_bits_reg;
  logic [CW-1:0]   tx_cnt_reg;

  wire             rx_valid_w;
  wire [7:0]       rx_data_w;
  wire             rx_perr_w;
  wire             err_any_w;
  wire             busy_w;
  wire             auth_w;
  wire             op_read_w;
  wire             op_seq_w;
  wire             op_write_w;
  wire             op_set_protect_bound_w;
  wire             op_change_passcode_w;
  wire             mem_op_w;
  addr_type        rx_addr_w;
  wire             read_ok_w;
  wire             write_ok_w;
  wire             prog_start_w;
  wire             last_code_w;
  wire [3:0]       change_passcode_len_w;
  status_word_type status_w;
  wire             tx_tick_w;
  wire [7:0]       pop_data_w;
  wire             even_par_w;

  byte_stream_if #(.WIDTH(8)) push_if ();
  byte_stream_if #(.WIDTH(8)) pop_if ();

  serial_rx #(.DIV(BAUD_DIV)) rx_unit (
    .clk_in         (clk_in),
    .rst_b_in       (rst_b_in),
    .clear_in       (!cs_in || err_any_w),
    .line_in        (serial_data_in),
    .parity_en_in   (parity_select_pin_in),
    .byte_valid_out (rx_valid_w),
    .byte_out       (rx_data_w),
    .parity_err_out (rx_perr_w)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) out_fifo (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .clear_in (!cs_in),
    .wr_in    (push_if),
    .rd_out   (pop_if)
  );

  // command decode and access checks
  assign err_any_w    = instr_err_reg || par_err_reg;
  assign busy_w       = prog_cnt_reg != '0;
  assign auth_w       = (code_len_reg == 4'h0) || access_en_reg;
  assign op_read_w    = rx_data_w[7:1] == `OPB_READ;
  assign op_seq_w     = rx_data_w[7:1] == `OPB_SEQ;
  assign op_write_w   = rx_data_w[7:1] == `OPB_WRITE;
  assign op_set_protect_bound_w    = rx_data_w[7:1] == `OPB_SET_PROTECT_BOUND;
  assign op_change_passcode_w    = rx_data_w[7:4] == `OPN_CHANGE_PASSCODE;
  assign change_passcode_len_w   = rx_data_w[3:0];
  assign mem_op_w     = op_read_w || op_seq_w || op_write_w;
  assign rx_addr_w    = {addr_reg[8], rx_data_w};
  assign read_ok_w    = auth_w || (rx_addr_w >= pointer_reg);
  assign write_ok_w   = prog_en_reg && auth_w && ((addr_reg >= pointer_reg) || bypass_reg);
  assign prog_start_w = state_reg == ST_DATA && rx_valid_w && write_ok_w;
  assign last_code_w  = (cnt_reg + 4'h1) == (op_reg == `OP_UNLOCK_WITH_CODE ? code_len_reg : new_len_reg);
  assign status_w     = {`STATUS_FIXED, par_err_reg, instr_err_reg, !busy_w, `STATUS_RSVD};

  // bytes for the output serializer
  assign push_if.valid = (state_reg == ST_PUSH) || (state_reg == ST_SEQ);
  assign push_if.data  = push_status_reg ? status_w : mem_reg[addr_reg];

  always_ff @(posedge clk_in) begin
    if (prog_start_w) begin
      mem_reg[addr_reg] <= rx_data_w;
    end
  end

  // program cycle timer; chip select does not stop it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prog_cnt_reg  <= '0;
      hold_high_reg <= 1'b0;
    end else begin
      if (prog_start_w) prog_cnt_reg <= PW'(PROG_CYCLES);
      else if (busy_w) prog_cnt_reg <= prog_cnt_reg - 1'b1;
      if (busy_w && prog_cnt_reg == PW'(1) && busy_en_reg) hold_high_reg <= 1'b1;
      else if ((state_reg == ST_IDLE && rx_valid_w) || err_any_w) hold_high_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg       <= ST_IDLE;
      op_reg          <= 8'h00;
      addr_reg        <= 9'h000;
      pointer_reg     <= `PTR_RESET;
      cnt_reg         <= 4'h0;
      code_len_reg    <= `CODE_LEN_RST;
      new_len_reg     <= 4'h0;
      match_reg       <= 1'b0;
      prog_en_reg     <= 1'b0;
      access_en_reg   <= 1'b0;
      bypass_reg      <= 1'b0;
      busy_en_reg     <= 1'b0;
      instr_err_reg   <= 1'b0;
      par_err_reg     <= 1'b0;
      push_status_reg <= 1'b0;
      for (int i = 0; i < `CODE_MAX; i++) code_reg[i] <= 8'h00;
    end else if (!cs_in) begin
      state_reg     <= ST_IDLE;
      instr_err_reg <= 1'b0;
      par_err_reg   <= 1'b0;
    end else if (rx_perr_w) begin
      par_err_reg <= 1'b1;
      state_reg   <= ST_ERROR;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (rx_valid_w) begin
            op_reg          <= rx_data_w;
            addr_reg        <= {rx_data_w[0], 8'h00};
            cnt_reg         <= 4'h0;
            match_reg       <= 1'b1;
            push_status_reg <= 1'b0;
            if (mem_op_w && busy_w) begin
              instr_err_reg <= 1'b1;
              state_reg     <= ST_ERROR;
            end else if (mem_op_w) begin
              state_reg <= ST_ADDR;
            end else if (op_set_protect_bound_w || rx_data_w == `OP_ONE_SHOT_BOUND_BYPASS) begin
              if (!auth_w) begin
                instr_err_reg <= 1'b1;
                state_reg     <= ST_ERROR;
              end else if (op_set_protect_bound_w) begin
                state_reg <= ST_ADDR;
              end else begin
                bypass_reg <= 1'b1;
              end
            end else if (op_change_passcode_w) begin
              new_len_reg <= change_passcode_len_w;
              if (!auth_w || !prog_en_reg || change_passcode_len_w > 4'(`CODE_MAX)) begin
                instr_err_reg <= 1'b1;
                state_reg     <= ST_ERROR;
              end else if (change_passcode_len_w == 4'h0) begin
                code_len_reg  <= 4'h0;
                access_en_reg <= 1'b0;
              end else begin
                state_reg <= ST_CODE;
              end
            end else begin
              case (rx_data_w)
                `OP_EWEN:   prog_en_reg <= 1'b1;
                `OP_EWDS:   prog_en_reg <= 1'b0;
                `OP_BUSY_SIGNAL_ON_CMD:  busy_en_reg <= 1'b1;
                `OP_DISBSY: busy_en_reg <= 1'b0;
                `OP_DISAC:  access_en_reg <= 1'b0;
                `OP_NOP:    state_reg <= ST_IDLE;
                `OP_UNLOCK_WITH_CODE: begin
                  if (code_len_reg == 4'h0) access_en_reg <= 1'b1;
                  else state_reg <= ST_CODE;
                end
                `OP_RSR: begin
                  push_status_reg <= 1'b1;
                  state_reg       <= ST_PUSH;
                end
                default: begin
                  instr_err_reg <= 1'b1;
                  state_reg     <= ST_ERROR;
                end
              endcase
            end
          end
        end
        ST_ADDR: begin
          if (rx_valid_w) begin
            addr_reg <= rx_addr_w;
            if (op_reg[7:1] == `OPB_SET_PROTECT_BOUND) begin
              pointer_reg <= rx_addr_w;
              state_reg   <= ST_IDLE;
            end else if (op_reg[7:1] == `OPB_WRITE) begin
              state_reg <= ST_DATA;
            end else if (!read_ok_w) begin
              instr_err_reg <= 1'b1;
              state_reg     <= ST_ERROR;
            end else begin
              state_reg <= (op_reg[7:1] == `OPB_SEQ) ? ST_SEQ : ST_PUSH;
            end
          end
        end
        ST_DATA: begin
          if (rx_valid_w) begin
            bypass_reg <= 1'b0;
            state_reg  <= ST_IDLE;
          end
        end
        ST_CODE: begin
          if (rx_valid_w) begin
            cnt_reg <= cnt_reg + 4'h1;
            if (op_reg == `OP_UNLOCK_WITH_CODE) begin
              if (last_code_w) access_en_reg <= match_reg && (rx_data_w == code_reg[cnt_reg[2:0]]);
              else match_reg <= match_reg && (rx_data_w == code_reg[cnt_reg[2:0]]);
            end else begin
              code_reg[cnt_reg[2:0]] <= rx_data_w;
              if (last_code_w) code_len_reg <= new_len_reg;
            end
            if (last_code_w) state_reg <= ST_IDLE;
          end
        end
        ST_PUSH: begin
          if (push_if.ready) state_reg <= ST_IDLE;
        end
        ST_SEQ: begin
          if (push_if.ready) begin
            if (addr_reg == `ADDR_LAST) state_reg <= ST_IDLE;
            else addr_reg <= addr_reg + 9'h001;
          end
        end
        ST_ERROR: state_reg <= ST_ERROR;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  // output serializer: start, 8 data bits lsb first, optional parity, stop
  assign tx_tick_w    = tx_active_reg && (tx_cnt_reg == '0);
  assign pop_data_w   = pop_if.data;
  assign even_par_w   = ^pop_data_w;
  assign pop_if.ready = cs_in && !err_any_w && !tx_active_reg;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_active_reg <= 1'b0;
      tx_shift_reg  <= 11'h7FF;
      tx_bits_reg   <= 4'h0;
      tx_cnt_reg    <= '0;
    end else if (!cs_in || err_any_w) begin
      tx_active_reg <= 1'b0;
    end else if (pop_if.valid && pop_if.ready) begin
      tx_active_reg <= 1'b1;
      tx_cnt_reg    <= CW'(BAUD_DIV - 1);
      tx_bits_reg   <= parity_select_pin_in ? 4'hB : 4'hA;
      tx_shift_reg  <= parity_select_pin_in ? {1'b1, even_par_w, pop_data_w, 1'b0}
                                            : {2'b11, pop_data_w, 1'b0};
    end else if (tx_tick_w) begin
      tx_cnt_reg   <= CW'(BAUD_DIV - 1);
      tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
      tx_bits_reg  <= tx_bits_reg - 4'h1;
      if (tx_bits_reg == 4'h1) tx_active_reg <= 1'b0;
    end else if (tx_active_reg) begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end
  end

  // pins
  assign serial_data_oe_out = cs_in && !err_any_w &&
                              (tx_active_reg || (busy_w && busy_en_reg) || hold_high_reg);
  assign serial_data_out    = tx_active_reg ? tx_shift_reg[0] : !busy_w;
  assign err_out            = 1'b0;
  assign err_oe_out         = err_any_w;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) status_out <= 8'h00;
    else status_out <= status_w;
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_CS_FLOATS_OUTPUT: assert property (!cs_in |=> !cs_in |-> !serial_data_oe_out)
    else $error("data output driven with chip select low");
  AST_ERROR_FLOATS_OUTPUT: assert property ($rose(instr_err_reg) |-> ##[0:1] !serial_data_oe_out)
    else $error("data output driven in error");
  AST_ERROR_PIN_HOLDS: assert property (err_oe_out && cs_in |=> err_oe_out && !err_out)
    else $error("error pin released without chip select low");
  AST_ENABLES_SURVIVE_CS: assert property ($fell(cs_in) |=> $stable(prog_en_reg) && $stable(access_en_reg))
    else $error("enable changed by chip select");
  AST_PROG_RUNS_ON: assert property (prog_cnt_reg > PW'(1) |=> busy_w && prog_cnt_reg == $past(prog_cnt_reg) - 1'b1)
    else $error("program cycle interrupted");
  AST_BUSY_DRIVES_LOW: assert property (busy_w && busy_en_reg && cs_in && !err_any_w && !tx_active_reg |-> serial_data_oe_out && !serial_data_out)
    else $error("busy not shown low");
  AST_NO_BUSY_FLOATS: assert property (busy_w && !busy_en_reg && !tx_active_reg && !hold_high_reg |-> !serial_data_oe_out)
    else $error("output driven during program without busy indication");
  AST_WRITE_ABOVE_BOUND: assert property (prog_start_w |-> (addr_reg >= pointer_reg || bypass_reg) ##1 busy_w && !bypass_reg)
    else $error("program below bound without bypass");
  AST_ERROR_STOPS_INPUT: assert property (state_reg == ST_ERROR && cs_in |=> state_reg == ST_ERROR && !tx_active_reg)
    else $error("activity after instruction error");
endmodule
`default_nettype wire

/* verification/host_link_model.sv */
// host model: serial byte sender and frame receiver
// assumes lsb first, even parity when enabled, one stop bit, line idles high
`default_nettype none
module host_link_model #(parameter int DIV = 8) (
  input  wire logic  clk_in,
  input  wire logic  par_in,
  input  wire logic  listen_in,
  input  wire logic  dout_in,
  input  wire logic  oe_in,
  output logic       line_out,
  output logic       got_out,
  output logic [7:0] byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    line_out = 1'b1;
    got_out = 1'b0;
    byte_out = 8'h00;
  end
  task automatic bit_out(input logic b);
    line_out = b;
    repeat (DIV) @(posedge clk_in);
    #1;
  endtask
  task automatic send(input logic [7:0] b, input logic bad);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(b[i]);
    end
    if (par_in) begin
      bit_out(^b ^ bad);
    end
    bit_out(1'b1);
  endtask
  always begin
    @(posedge clk_in);
    if (listen_in && oe_in && !dout_in) begin
      repeat (DIV / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge clk_in);
        byte_out[i] = dout_in;
      end
      repeat (par_in ? 2 * DIV : DIV) @(posedge clk_in);
      #1 got_out = 1'b1;
      @(posedge clk_in);
      #1 got_out = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* verification/testbench.sv */
// self-checking bench for the secure serial memory front end
// assumes the core sources and host_link_model compiled first
`default_nettype none
`include "sec_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 8;
  logic        clk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic        cs_in = 1'b0;
  logic        par = 1'b0;
  logic        listen = 1'b1;
  logic        line, dout, oe, err, err_oe, got;
  logic [7:0]  gbyte, stat;
  logic [31:0] seed = 32'h596D;
  logic [7:0]  q[$];
  int          mismatches = 0;
  int          checked = 0;
  always #20 clk_in = ~clk_in;
  secure_serial_eeprom_front_end #(.PROG_CYCLES(50), .BAUD_DIV(DIV), .FIFO_DEPTH(32))
    u_secure_serial_eeprom_front_end (.clk_in(clk_in), .rst_b_in(rst_b_in), .cs_in(cs_in),
    .serial_data_in(line), .parity_select_pin_in(par), .serial_data_out(dout),
    .serial_data_oe_out(oe), .err_out(err), .err_oe_out(err_oe), .status_out(stat));
  host_link_model #(.DIV(DIV)) u_host_link_model (.clk_in(clk_in), .par_in(par),
    .listen_in(listen), .dout_in(dout), .oe_in(oe), .line_out(line), .got_out(got),
    .byte_out(gbyte));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] a);
    checked++;
    if (a !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t byte exp %h got %h", $time, e, a);
    end
  endtask
  task automatic chk_bit(input logic e, input logic a);
    checked++;
    if (a !== e) begin
      mismatches++;
      $display("CHECK FAILED %0t pin exp %b got %b", $time, e, a);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    if (got === 1'b1) begin
      if (q.size() == 0) begin
        mismatches++;
        $display("CHECK FAILED %0t unexpected byte %h", $time, gbyte);
      end else chk_byte(q.pop_front(), gbyte);
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic tx(input logic [7:0] b);
    u_host_link_model.send(b, 1'b0);
  endtask
  task automatic csp;
    cs_in = 1'b0;
    tick(2);
    cs_in = 1'b1;
    tick(2);
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic bsy);
    listen = !bsy;
    tx({`OPB_WRITE, a[8]});
    tx(a[7:0]);
    tx(d);
    tick(20);
    chk_bit(bsy, oe);
    if (bsy) chk_bit(1'b0, dout);
    if (bsy) chk_bit(1'b0, stat[2]);
    tick(50);
    if (bsy) chk_bit(1'b1, dout);
    listen = 1'b1;
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] d);
    q.push_back(d);
    tx({`OPB_READ, a[8]});
    tx(a[7:0]);
    tick(100);
  endtask
  initial begin
    logic [7:0] d0;
    logic [7:0] d1;
    tick(2);
    rst_b_in = 1'b1;
    cs_in = 1'b1;
    tick(2);
    chk_byte(8'hA4, stat);
    q.push_back(8'hA4);
    tx(`OP_RSR);
    tick(100);
    tx(`OP_EWEN);
    csp();
    seed = xs(seed);
    d0 = seed[7:0];
    seed = xs(seed);
    d1 = seed[7:0];
    wr(9'h010, d0, 1'b0);
    rd(9'h010, d0);
    tx({`OPB_SET_PROTECT_BOUND, 1'b0});
    tx(8'h20);
    wr(9'h010, d1, 1'b0);
    rd(9'h010, d0);
    tx(`OP_ONE_SHOT_BOUND_BYPASS);
    wr(9'h010, d1, 1'b0);
    rd(9'h010, d1);
    tx(`OP_BUSY_SIGNAL_ON_CMD);
    wr(9'h1FE, d0, 1'b1);
    wr(9'h1FF, d1, 1'b1);
    q.push_back(d0);
    q.push_back(d1);
    tx({`OPB_SEQ, 1'b1});
    tx(8'hFE);
    tick(250);
    chk_bit(1'b0, oe);
    par = 1'b1;
    tick(2);
    q.push_back(8'hA4);
    tx(`OP_RSR);
    tick(120);
    u_host_link_model.send(`OP_RSR, 1'b1);
    tick(5);
    chk_bit(1'b1, err_oe);
    chk_bit(1'b0, err);
    chk_bit(1'b1, stat[4]);
    tick(120);
    chk_bit(1'b0, oe);
    csp();
    chk_bit(1'b0, err_oe);
    par = 1'b0;
    tick(2);
    tx(8'hFF);
    tick(5);
    chk_bit(1'b1, err_oe);
    chk_bit(1'b1, stat[3]);
    tx(`OP_RSR);
    tick(120);
    chk_bit(1'b0, oe);
    csp();
    conclude();
  end
  initial begin
    #1_000_000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
